/* design/ssap_slave.sv */
// slave end: address match, pointer, register strobes and alert response
`timescale 1ns/1ps
module ssap_slave (
	input  wire logic       CLK_IN,
	input  wire logic       RST_N_IN,
	input  wire logic       CE_IN,
	ssap_if.slave           LINK,
	input  wire logic [3:0] ADDR_STRAP_IN,
	input  wire logic       IRQ_ACTIVE_IN,
	input  wire logic [7:0] RD_DATA_IN,
	output logic            WR_STB_OUT,
	output logic            RD_STB_OUT,
	output logic [7:0]      ACC_ADDR_OUT,
	output logic [7:0]      WR_DATA_OUT,
	output logic [7:0]      PTR_OUT,
	output logic [3:0]      STRAP_ADDR_OUT
);
	import ssap_pkg::*;

	// ****************************************************************
	// input synchronisers and line events
	// ****************************************************************
	logic [1:0] scl_sync_r, sda_sync_r;
	logic       scl_d_r, sda_d_r;
	logic [3:0] strap_s1_r, strap_s2_r;

	// clock and data share one depth so their order is preserved
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			{scl_sync_r, sda_sync_r, scl_d_r, sda_d_r} <= 6'h3f;
			{strap_s2_r, strap_s1_r} <= {SSAP_STRAP_RST, SSAP_STRAP_RST};
		end else if (CE_IN) begin
			scl_sync_r <= {scl_sync_r[0], LINK.scl};
			sda_sync_r <= {sda_sync_r[0], LINK.serial_data_input};
			{scl_d_r, sda_d_r}       <= {scl_sync_r[1], sda_sync_r[1]};
			{strap_s2_r, strap_s1_r} <= {strap_s1_r, ADDR_STRAP_IN};
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

	// data edges count only while the clock stays high
	assign scl_s     = scl_sync_r[1];
	assign sda_s     = sda_sync_r[1];
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign start_det = scl_s & scl_d_r & ~sda_s & sda_d_r;
	assign stop_det  = scl_s & scl_d_r & sda_s & ~sda_d_r;

	// ****************************************************************
	// strap capture
	// ****************************************************************
	logic [1:0] cap_cnt_r, cap_cnt_nxt;
	logic       cap_done_r, cap_done_nxt;
	logic [3:0] strap_r, strap_nxt;

	// waits for the synchroniser to fill, then freezes until next reset
	always_comb begin
		cap_cnt_nxt  = cap_cnt_r;
		cap_done_nxt = cap_done_r;
		strap_nxt    = strap_r;
		if (!cap_done_r) begin
			cap_cnt_nxt = 2'(cap_cnt_r + 2'h1);
			if (cap_cnt_r == SSAP_STRAP_WAIT) begin
				strap_nxt    = strap_s2_r;
				cap_done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			{cap_cnt_r, cap_done_r} <= 3'h0;
			strap_r    <= SSAP_STRAP_RST;
		end else if (CE_IN) begin
			{cap_cnt_r, cap_done_r} <= {cap_cnt_nxt, cap_done_nxt};
			strap_r    <= strap_nxt;
		end
	end

	logic [6:0] own_addr;
	assign own_addr = {SSAP_ADDR_PREFIX, strap_r};

	// ****************************************************************
	// transfer engine
	// ****************************************************************
	ssap_slv_state_type state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, acc_r, acc_nxt;
	logic [7:0] wdat_r, wdat_nxt, ptr_inc;
	logic       oe_r, oe_nxt, cmd_r, cmd_nxt, read_r, read_nxt;
	logic       alert_r, alert_nxt, wr_stb_r, wr_stb_nxt;
	logic       rd_stb_r, rd_stb_nxt, do_load;

	// saturating so a long burst never lands on unbuilt registers
	assign ptr_inc = (ptr_r >= SSAP_PTR_TOP) ? ptr_r : 8'(ptr_r + 8'h1);

	// one decision per sampled clock edge; start and stop override all
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		shift_nxt  = shift_r;
		oe_nxt     = oe_r;
		cmd_nxt    = cmd_r;
		read_nxt   = read_r;
		alert_nxt  = alert_r;
		ptr_nxt    = ptr_r;
		wr_stb_nxt = 1'b0;
		rd_stb_nxt = 1'b0;
		acc_nxt    = acc_r;
		wdat_nxt   = wdat_r;
		do_load    = 1'b0;
		if (stop_det) begin
			state_nxt = SSAP_S_IDLE;
			oe_nxt    = 1'b0;
		end else if (start_det) begin
			state_nxt = SSAP_S_ADDR;
			cnt_nxt   = 4'h0;
			oe_nxt    = 1'b0;
			alert_nxt = 1'b0;
		end else begin
			case (state_r)
				SSAP_S_ADDR, SSAP_S_RX: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_s};
						cnt_nxt   = 4'(cnt_r + 4'h1);
					end
					if (scl_fall && cnt_r == SSAP_BITS_PER_BYTE) begin
						state_nxt = SSAP_S_RX_ACK;
						oe_nxt    = 1'b1;
						if (state_r == SSAP_S_ADDR) begin
							read_nxt = shift_r[0];
							cmd_nxt  = ~shift_r[0];
							if (shift_r[7:1] == own_addr) begin
								alert_nxt = 1'b0;
							end else if (shift_r[7:1] == SSAP_GLOBAL_ADDR &&
								!shift_r[0]) begin
								alert_nxt = 1'b0;
							end else if (shift_r[7:1] == SSAP_GLOBAL_ADDR &&
								IRQ_ACTIVE_IN) begin
								alert_nxt = 1'b1;
							end else begin
								state_nxt = SSAP_S_IGNORE;
								oe_nxt    = 1'b0;
							end
						end else if (cmd_r) begin
							ptr_nxt = shift_r;
							cmd_nxt = 1'b0;
						end else begin
							wr_stb_nxt = 1'b1;
							acc_nxt    = ptr_r;
							wdat_nxt   = shift_r;
							ptr_nxt    = ptr_inc;
						end
					end
				end
				SSAP_S_RX_ACK: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						do_load = read_r;
						if (!read_r) begin
							state_nxt = SSAP_S_RX;
							oe_nxt    = 1'b0;
						end
					end
				end
				SSAP_S_TX: begin
					if (scl_rise) begin
						cnt_nxt = 4'(cnt_r + 4'h1);
						if (alert_r && sda_s != shift_r[7]) begin
							state_nxt = SSAP_S_IGNORE;
							oe_nxt    = 1'b0;
						end
					end
					if (scl_fall) begin
						if (cnt_r == SSAP_BITS_PER_BYTE) begin
							state_nxt = SSAP_S_TX_ACK;
							oe_nxt    = 1'b0;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b1};
							oe_nxt    = ~shift_r[6];
						end
					end
				end
				SSAP_S_TX_ACK: begin
					// a refusal or a finished alert reply ends our part
					if (scl_rise && (sda_s || alert_r)) begin
						state_nxt = SSAP_S_IGNORE;
					end else if (scl_fall) begin
						cnt_nxt = 4'h0;
						do_load = 1'b1;
					end
				end
				SSAP_S_IDLE, SSAP_S_IGNORE: begin
					oe_nxt = 1'b0;
				end
				default: begin
					state_nxt = SSAP_S_IDLE;
					oe_nxt    = 1'b0;
				end
			endcase
		end
		// next outgoing byte: own address for alert, else the pointed register
		if (do_load) begin
			state_nxt = SSAP_S_TX;
			if (alert_r) begin
				shift_nxt = {own_addr, 1'b0};
			end else begin
				shift_nxt  = RD_DATA_IN;
				rd_stb_nxt = 1'b1;
				acc_nxt    = ptr_r;
				ptr_nxt    = ptr_inc;
			end
			oe_nxt = ~shift_nxt[7];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_r  <= SSAP_S_IDLE;
			cnt_r    <= 4'h0;
			shift_r  <= 8'hff;
			{oe_r, cmd_r, read_r, alert_r} <= 4'h0;
			ptr_r    <= SSAP_PTR_RST;
			{wr_stb_r, rd_stb_r} <= 2'h0;
			{acc_r, wdat_r}      <= {SSAP_PTR_RST, 8'h00};
		end else if (CE_IN) begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			shift_r  <= shift_nxt;
			{oe_r, cmd_r, read_r, alert_r} <= {oe_nxt, cmd_nxt, read_nxt, alert_nxt};
			ptr_r    <= ptr_nxt;
			{wr_stb_r, rd_stb_r} <= {wr_stb_nxt, rd_stb_nxt};
			{acc_r, wdat_r}      <= {acc_nxt, wdat_nxt};
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// only ever pulls low; the line idles high through the pullup
	assign LINK.serial_data_output_open_drain_oe = oe_r;
	assign LINK.serial_data_output_open_drain_o  = 1'b0;
	assign WR_STB_OUT     = wr_stb_r;
	assign RD_STB_OUT     = rd_stb_r;
	assign ACC_ADDR_OUT   = acc_r;
	assign WR_DATA_OUT    = wdat_r;
	assign PTR_OUT        = ptr_r;
	assign STRAP_ADDR_OUT = strap_r;
endmodule

/* design/ssap_pkg.sv */
// shared constants and types for the serial slave alert port and its master end
package ssap_pkg;

	// ****************************************************************
	// addressing
	// ****************************************************************
	localparam logic [2:0] SSAP_ADDR_PREFIX  = 3'h2;    // fixed upper three address bits
	localparam logic [6:0] SSAP_GLOBAL_ADDR  = 7'h30;   // broadcast write / alert response
	localparam logic [3:0] SSAP_STRAP_RST    = 4'hf;    // straps idle high through pullups
	localparam logic [1:0] SSAP_STRAP_WAIT   = 2'h2;    // edges after release before capture

	// ****************************************************************
	// pointer and framing
	// ****************************************************************
	localparam logic [7:0] SSAP_PTR_RST      = 8'h00;
	localparam logic [7:0] SSAP_PTR_TOP      = 8'h26;   // pointer saturates here
	localparam logic [3:0] SSAP_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] SSAP_BITS_PER_SLOT = 4'h9;   // eight data bits plus acknowledge

	// ****************************************************************
	// timing of the master's serial clock
	// ****************************************************************
	localparam int SSAP_CLK_PERIOD_NS = 10;
	localparam int SSAP_SCL_PERIOD_NS = 1000;
	localparam int SSAP_SCL_QTR_CYC   = SSAP_SCL_PERIOD_NS / (4 * SSAP_CLK_PERIOD_NS);

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		SSAP_S_IDLE   = 3'h0,
		SSAP_S_ADDR   = 3'h1,
		SSAP_S_RX     = 3'h2,
		SSAP_S_RX_ACK = 3'h3,
		SSAP_S_TX     = 3'h4,
		SSAP_S_TX_ACK = 3'h5,
		SSAP_S_IGNORE = 3'h6
	} ssap_slv_state_type;

	typedef enum logic [1:0] {
		SSAP_M_IDLE  = 2'h0,
		SSAP_M_START = 2'h1,
		SSAP_M_BIT   = 2'h2,
		SSAP_M_STOP  = 2'h3
	} ssap_mst_state_type;

	typedef enum logic [1:0] {
		SSAP_CMD_START = 2'h0,
		SSAP_CMD_WRITE = 2'h1,
		SSAP_CMD_READ  = 2'h2,
		SSAP_CMD_STOP  = 2'h3
	} ssap_cmd_type;

endpackage

/* design/ssap_if.sv */
// serial link between master end and slave end, with wired-and data line
`timescale 1ns/1ps
interface ssap_if;

	// ****************************************************************
	// link signals
	// ****************************************************************
	logic scl;                                  // driven by the master only
	logic sda_mst_o;                            // master data value (always low)
	logic sda_mst_oe;                           // master pulls the line low
	logic serial_data_output_open_drain_o;      // slave data value (always low)
	logic serial_data_output_open_drain_oe;     // slave pulls the line low
	logic serial_data_input;                    // resolved line level seen by both

	// pullup wins unless someone drives low
	assign serial_data_input = !((sda_mst_oe && !sda_mst_o) ||
		(serial_data_output_open_drain_oe && !serial_data_output_open_drain_o));

	modport master (
		output scl,
		output sda_mst_o,
		output sda_mst_oe,
		input  serial_data_input
	);

	modport slave (
		input  scl,
		input  serial_data_input,
		output serial_data_output_open_drain_o,
		output serial_data_output_open_drain_oe
	);

endinterface

/* design/ssap_master.sv */
// master end: generates the serial clock and runs byte-level commands
`timescale 1ns/1ps
module ssap_master #(
	parameter int SCL_QTR_CYC = ssap_pkg::SSAP_SCL_QTR_CYC
) (
	input  wire logic                  CLK_IN,
	input  wire logic                  RST_N_IN,
	input  wire logic                  CE_IN,
	ssap_if.master                     LINK,
	input  wire logic                  CMD_VALID_IN,
	input  wire ssap_pkg::ssap_cmd_type CMD_IN,
	input  wire logic [7:0]            CMD_DATA_IN,
	input  wire logic                  CMD_NACK_IN,
	output logic                       CMD_READY_OUT,
	output logic                       RX_VALID_OUT,
	output logic [7:0]                 RX_DATA_OUT,
	output logic                       RX_ACK_OUT
);
	import ssap_pkg::*;

	// sync delay plus slave reaction must fit inside one quarter
	if (SCL_QTR_CYC < 4 || SCL_QTR_CYC > 65535) begin : g_chk
		$error("ssap_master: SCL_QTR_CYC out of range");
	end

	localparam logic [15:0] QTR_LAST = 16'(SCL_QTR_CYC - 1);

	// ****************************************************************
	// data line synchroniser
	// ****************************************************************
	logic [1:0] sda_sync_r;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sda_sync_r <= 2'h3;
		end else if (CE_IN) begin
			sda_sync_r <= {sda_sync_r[0], LINK.serial_data_input};
		end
	end

	// ****************************************************************
	// command sequencer
	// ****************************************************************
	ssap_mst_state_type state_r, state_nxt;
	logic [15:0] qcnt_r, qcnt_nxt;
	logic [1:0]  qtr_r, qtr_nxt;
	logic [3:0]  bits_r, bits_nxt;
	logic [8:0]  txsh_r, txsh_nxt;
	logic [8:0]  rxsh_r, rxsh_nxt;
	logic        scl_r, scl_nxt;
	logic        oe_r, oe_nxt;
	logic        ready_r, ready_nxt;
	logic        rxv_r, rxv_nxt;
	logic [7:0]  rxd_r, rxd_nxt;
	logic        rxa_r, rxa_nxt;
	logic        tick;

	// each bit is four quarters: data set, clock high, sample, clock low
	always_comb begin
		tick      = (qcnt_r == QTR_LAST);
		state_nxt = state_r;
		qcnt_nxt  = tick ? 16'h0 : 16'(qcnt_r + 16'h1);
		qtr_nxt   = tick ? 2'(qtr_r + 2'h1) : qtr_r;
		bits_nxt  = bits_r;
		txsh_nxt  = txsh_r;
		rxsh_nxt  = rxsh_r;
		ready_nxt = ready_r;
		rxv_nxt   = 1'b0;
		rxd_nxt   = rxd_r;
		rxa_nxt   = rxa_r;
		case (state_r)
			SSAP_M_IDLE: begin
				qcnt_nxt = 16'h0;
				qtr_nxt  = 2'h0;
				if (CMD_VALID_IN && ready_r) begin
					ready_nxt = 1'b0;
					bits_nxt  = 4'h0;
					case (CMD_IN)
						SSAP_CMD_START: state_nxt = SSAP_M_START;
						SSAP_CMD_STOP:  state_nxt = SSAP_M_STOP;
						SSAP_CMD_WRITE: begin
							state_nxt = SSAP_M_BIT;
							txsh_nxt  = {CMD_DATA_IN, 1'b1};  // release for slave ack
						end
						default: begin
							state_nxt = SSAP_M_BIT;
							txsh_nxt  = {8'hff, CMD_NACK_IN};
						end
					endcase
				end
			end
			SSAP_M_START, SSAP_M_STOP: begin
				if (tick && qtr_r == 2'h3) begin
					state_nxt = SSAP_M_IDLE;
					ready_nxt = 1'b1;
				end
			end
			SSAP_M_BIT: begin
				if (tick && qtr_r == 2'h2) begin
					rxsh_nxt = {rxsh_r[7:0], sda_sync_r[1]};
				end
				if (tick && qtr_r == 2'h3) begin
					bits_nxt = 4'(bits_r + 4'h1);
					txsh_nxt = {txsh_r[7:0], 1'b1};
					if (bits_r == SSAP_BITS_PER_SLOT - 4'h1) begin
						state_nxt = SSAP_M_IDLE;
						ready_nxt = 1'b1;
						rxv_nxt   = 1'b1;
						rxd_nxt   = rxsh_r[8:1];
						rxa_nxt   = ~rxsh_r[0];
					end
				end
			end
			default: state_nxt = SSAP_M_IDLE;
		endcase
		// pins follow the upcoming quarter so they leave a flop
		scl_nxt = scl_r;
		oe_nxt  = oe_r;
		case (state_nxt)
			SSAP_M_START: begin
				oe_nxt  = (qtr_nxt >= 2'h2);
				scl_nxt = (qtr_nxt == 2'h0) ? scl_r : (qtr_nxt != 2'h3);
			end
			SSAP_M_BIT: begin
				oe_nxt  = ~txsh_nxt[8];
				scl_nxt = (qtr_nxt == 2'h1) || (qtr_nxt == 2'h2);
			end
			SSAP_M_STOP: begin
				oe_nxt  = (qtr_nxt < 2'h2);
				scl_nxt = (qtr_nxt != 2'h0);
			end
			default: begin
				oe_nxt  = oe_r;
				scl_nxt = scl_r;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_r <= SSAP_M_IDLE;
			qcnt_r  <= 16'h0;
			qtr_r   <= 2'h0;
			bits_r  <= 4'h0;
			txsh_r  <= 9'h1ff;
			rxsh_r  <= 9'h1ff;
			scl_r   <= 1'b1;
			oe_r    <= 1'b0;
			ready_r <= 1'b1;
			rxv_r   <= 1'b0;
			rxd_r   <= 8'h00;
			rxa_r   <= 1'b0;
		end else if (CE_IN) begin
			state_r <= state_nxt;
			qcnt_r  <= qcnt_nxt;
			qtr_r   <= qtr_nxt;
			bits_r  <= bits_nxt;
			txsh_r  <= txsh_nxt;
			rxsh_r  <= rxsh_nxt;
			scl_r   <= scl_nxt;
			oe_r    <= oe_nxt;
			ready_r <= ready_nxt;
			rxv_r   <= rxv_nxt;
			rxd_r   <= rxd_nxt;
			rxa_r   <= rxa_nxt;
		end
	end

	assign LINK.scl        = scl_r;
	assign LINK.sda_mst_oe = oe_r;
	assign LINK.sda_mst_o  = 1'b0;
	assign CMD_READY_OUT   = ready_r;
	assign RX_VALID_OUT    = rxv_r;
	assign RX_DATA_OUT     = rxd_r;
	assign RX_ACK_OUT      = rxa_r;

endmodule

/* bench/ssap_checker.sv */
// checker on the serial link and the slave end's register-side strobes
`timescale 1ns/1ps
module ssap_checker (
	input wire logic       CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic       scl,
	input wire logic       serial_data_input,
	input wire logic       serial_data_output_open_drain_o,
	input wire logic       serial_data_output_open_drain_oe,
	input wire logic       WR_STB_OUT,
	input wire logic       RD_STB_OUT,
	input wire logic [7:0] ACC_ADDR_OUT,
	input wire logic [7:0] PTR_OUT,
	input wire logic [3:0] STRAP_ADDR_OUT
);
	import ssap_pkg::*;

	// ****************************************************************
	// helper count of edges since reset release
	// ****************************************************************
	logic [2:0] rel_cnt_r;
	logic [2:0] rel_cnt_nxt;

	// saturates so the strap capture edge stays identifiable
	always_comb begin
		rel_cnt_nxt = rel_cnt_r;
		if (rel_cnt_r != 3'h7)
			rel_cnt_nxt = rel_cnt_r + 3'h1;
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			rel_cnt_r <= 3'h0;
		else
			rel_cnt_r <= rel_cnt_nxt;
	end

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	// ****************************************************************
	// properties
	// ****************************************************************
	property p_od_low;
		serial_data_output_open_drain_oe |-> !serial_data_output_open_drain_o;
	endproperty
	a_od_low: assert property (p_od_low)
		else $error("slave drives data line high");

	// slave may only move its data while the clock is low
	property p_slave_hold;
		$changed(serial_data_output_open_drain_oe) |-> !scl && !$past(scl);
	endproperty
	a_slave_hold: assert property (p_slave_hold)
		else $error("slave data changed with clock high");

	property p_oe_stands;
		$rose(serial_data_output_open_drain_oe) |-> serial_data_output_open_drain_oe [*8];
	endproperty
	a_oe_stands: assert property (p_oe_stands)
		else $error("slave low drive too short");

	property p_wr_ptr;
		WR_STB_OUT |-> PTR_OUT == ((ACC_ADDR_OUT >= SSAP_PTR_TOP) ? ACC_ADDR_OUT :
			ACC_ADDR_OUT + 8'h01);
	endproperty
	a_wr_ptr: assert property (p_wr_ptr)
		else $error("pointer wrong after write");

	property p_rd_ptr;
		RD_STB_OUT |-> PTR_OUT == ((ACC_ADDR_OUT >= SSAP_PTR_TOP) ? ACC_ADDR_OUT :
			ACC_ADDR_OUT + 8'h01);
	endproperty
	a_rd_ptr: assert property (p_rd_ptr)
		else $error("pointer wrong after read");

	property p_wr_pulse;
		WR_STB_OUT |=> !WR_STB_OUT;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe longer than one cycle");

	property p_strap_once;
		$changed(STRAP_ADDR_OUT) |-> rel_cnt_r == 3'h3;
	endproperty
	a_strap_once: assert property (p_strap_once)
		else $error("strap address changed outside capture");

	// after a stop the slave keeps the bus free
	property p_idle_free;
		scl && $past(scl) && $rose(serial_data_input) |=>
			!serial_data_output_open_drain_oe [*8];
	endproperty
	a_idle_free: assert property (p_idle_free)
		else $error("slave drives after stop");

	c_top_write: cover property (WR_STB_OUT && PTR_OUT == SSAP_PTR_TOP);
	c_read: cover property (RD_STB_OUT);
	c_ack: cover property ($rose(serial_data_output_open_drain_oe));
endmodule

/* bench/serial_slave_alert_port_bench.sv */
// bench: master and slave ends joined over the serial link, random traffic
`timescale 1ns/1ps
module serial_slave_alert_port_bench;
	import ssap_pkg::*;

	// ****************************************************************
	// signals
	// ****************************************************************
	logic         clk;
	logic         rst_n;
	logic         cmd_valid;
	ssap_cmd_type cmd;
	logic [7:0]   cmd_data;
	logic         cmd_nack;
	logic         irq;
	logic [3:0]   strap;
	logic         cmd_ready;
	logic         rx_valid;
	logic [7:0]   rx_data;
	logic         rx_ack;
	logic         wr_stb;
	logic         rd_stb;
	logic [7:0]   acc_addr;
	logic [7:0]   wr_data;
	logic [7:0]   ptr;
	logic [3:0]   strap_cap;
	logic [7:0]   regs [0:255];
	logic [7:0]   expv [0:255];
	logic [31:0]  seed;
	logic [6:0]   own;
	int           n_fail;
	int           checks_done;

	ssap_if link_bus ();
	ssap_master #(.SCL_QTR_CYC(5)) ssap_master_i (.CLK_IN(clk), .RST_N_IN(rst_n),
		.CE_IN(1'b1), .LINK(link_bus), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd),
		.CMD_DATA_IN(cmd_data), .CMD_NACK_IN(cmd_nack), .CMD_READY_OUT(cmd_ready),
		.RX_VALID_OUT(rx_valid), .RX_DATA_OUT(rx_data), .RX_ACK_OUT(rx_ack));
	ssap_slave ssap_slave_i (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
		.LINK(link_bus), .ADDR_STRAP_IN(strap), .IRQ_ACTIVE_IN(irq),
		.RD_DATA_IN(regs[ptr]), .WR_STB_OUT(wr_stb), .RD_STB_OUT(rd_stb),
		.ACC_ADDR_OUT(acc_addr), .WR_DATA_OUT(wr_data), .PTR_OUT(ptr),
		.STRAP_ADDR_OUT(strap_cap));
	ssap_checker ssap_checker_i (.CLK_IN(clk), .RST_N_IN(rst_n), .scl(link_bus.scl),
		.serial_data_input(link_bus.serial_data_input),
		.serial_data_output_open_drain_o(link_bus.serial_data_output_open_drain_o),
		.serial_data_output_open_drain_oe(link_bus.serial_data_output_open_drain_oe),
		.WR_STB_OUT(wr_stb), .RD_STB_OUT(rd_stb), .ACC_ADDR_OUT(acc_addr),
		.PTR_OUT(ptr), .STRAP_ADDR_OUT(strap_cap));

	// register file behind the slave strobes
	always @(posedge clk) begin
		if (wr_stb === 1'b1)
			regs[acc_addr] <= wr_data;
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	// expected pointer after one data byte: advances, but never past the top
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		return (p < SSAP_PTR_TOP) ? 8'(p + 8'h01) : p;
	endfunction

	task automatic summarize();
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one master command, bounded wait for the master to go idle again
	task automatic xfer(input ssap_cmd_type c, input logic [7:0] d, input logic nk);
		int i;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = c;
		cmd_data = d;
		cmd_nack = nk;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 400 && cmd_ready !== 1'b1; i++)
			@(negedge clk);
		if (i == 400) begin
			n_fail++;
			summarize();
		end else begin
			// the byte pulse stands for the one cycle in which ready returns
			check_bit(rx_valid, c == SSAP_CMD_WRITE || c == SSAP_CMD_READ);
		end
	endtask

	task automatic wr_frame(input logic [6:0] a, input logic [7:0] p, input int n,
		input logic hit);
		xfer(SSAP_CMD_START, 8'h00, 1'b0);
		xfer(SSAP_CMD_WRITE, {a, 1'b0}, 1'b0);
		check_bit(rx_ack, hit);
		xfer(SSAP_CMD_WRITE, p, 1'b0);
		if (hit)
			check(ptr, p);
		for (int k = 0; k < n; k++) begin
			seed = lfsr(seed);
			xfer(SSAP_CMD_WRITE, seed[7:0], 1'b0);
			if (hit)
				expv[p] = seed[7:0];
			if (hit)
				p = next_ptr(p);
		end
		if (hit)
			check(ptr, p);
		xfer(SSAP_CMD_STOP, 8'h00, 1'b0);
	endtask

	// set the pointer alone, then read n bytes from it
	task automatic readback(input logic [7:0] p, input int n);
		wr_frame(own, p, 0, 1'b1);
		xfer(SSAP_CMD_START, 8'h00, 1'b0);
		xfer(SSAP_CMD_WRITE, {own, 1'b1}, 1'b0);
		check_bit(rx_ack, 1'b1);
		for (int k = 0; k < n; k++) begin
			xfer(SSAP_CMD_READ, 8'h00, k == n - 1);
			check(rx_data, expv[p]);
			p = next_ptr(p);
		end
		xfer(SSAP_CMD_STOP, 8'h00, 1'b0);
	endtask

	task automatic alert(input logic pend);
		xfer(SSAP_CMD_START, 8'h00, 1'b0);
		xfer(SSAP_CMD_WRITE, {SSAP_GLOBAL_ADDR, 1'b1}, 1'b0);
		check_bit(rx_ack, pend);
		if (pend) begin
			xfer(SSAP_CMD_READ, 8'h00, 1'b1);
			check(rx_data, {own, 1'b0});
		end
		xfer(SSAP_CMD_STOP, 8'h00, 1'b0);
	endtask

	// ****************************************************************
	// clock and main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = SSAP_CMD_START;
		cmd_data = 8'h00;
		cmd_nack = 1'b0;
		irq = 1'b0;
		n_fail = 0;
		checks_done = 0;
		for (int i = 0; i < 256; i++) begin
			regs[i] = i[7:0] ^ 8'h5a;
			expv[i] = i[7:0] ^ 8'h5a;
		end
		seed = lfsr(32'h29583a2d);
		// all-ones would hide whether the capture happened
		strap = (seed[3:0] == 4'hf) ? 4'h6 : seed[3:0];
		own = {SSAP_ADDR_PREFIX, strap};
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check({4'h0, strap_cap}, {4'h0, strap});
		wr_frame(own, 8'h23, 5, 1'b1);
		wr_frame(own ^ 7'h01, 8'h23, 3, 1'b0);
		wr_frame(own ^ 7'h40, 8'h24, 2, 1'b0);
		wr_frame(SSAP_GLOBAL_ADDR, 8'h10, 2, 1'b1);
		readback(8'h22, 6);
		readback(8'h10, 2);
		repeat (3) begin
			seed = lfsr(seed);
			wr_frame(own, {3'h0, seed[4:0]}, 3, 1'b1);
			readback({3'h0, seed[4:0]}, 3);
		end
		irq = 1'b1;
		alert(1'b1);
		irq = 1'b0;
		alert(1'b0);
		summarize();
	end
endmodule
